// ### shared/alu_slice_pkg.sv
// Purpose: constants and types for the rotate/subtract datapath slice
// Assumes: 8-bit data, 7-bit file address, one instruction clock
// Notes: none
package alu_slice_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int NIB_W = 4;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [6:0] ADDR_MAX = 7'h7f;
  localparam int RETURN_CYCLES = 2;
  localparam logic [1:0] RETURN_LAST = 2'h1;
  localparam logic DEST_ACC = 1'h0;
  localparam logic DEST_FILE = 1'h1;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ROTATE_RIGHT,
    OP_ROTATE_LEFT,
    OP_LITERAL_MINUS_ACC,
    OP_RETURN_WITH_LITERAL
  } op_type;

  typedef struct packed {
    op_type op;
    logic dest;
    logic [6:0] addr;
    logic [7:0] literal;
    logic [7:0] file_data;
  } request_type;

  typedef struct packed {
    logic carry;
    logic nibble_carry;
    logic zero;
  } flags_type;
endpackage : alu_slice_pkg

// ### rtl/rotate_subtract_alu_slice.sv
// Purpose: rotate-through-carry, literal-minus-accumulator and return-with-literal slice
// Assumes: decoder issues one request per cycle while o_BUSY is low; file data arrives with request
// Notes: flags and accumulator are held here; file write-back and pc reload are one-cycle strobes
`timescale 1ns/1ps

// What this block does
// [RL1] rotate right shifts file register right through carry; old carry to bit 7
// [RL2] rotate destination 0 writes accumulator, 1 writes back the file register
// [RL3] literal-minus-accumulator computes literal minus accumulator in two's complement
// [RL4] the difference always goes to accumulator; carry, nibble carry, zero updated
// [RL5] carry is 0 when accumulator exceeds literal; nibble carry likewise on low nibble
// [RL6] return-with-literal takes two instruction cycles
// [RL7] return-with-literal loads accumulator with literal and reloads pc from stack top
// [RL8] rotate left goes through carry, same destination choice, touches carry only
module rotate_subtract_alu_slice (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic I_VALID,
  input wire alu_slice_pkg::request_type I_REQ,
  output logic O_BUSY,
  output logic [7:0] O_ACC,
  output alu_slice_pkg::flags_type O_FLAGS,
  output logic O_FILE_WE,
  output logic [6:0] O_FILE_ADDR,
  output logic [7:0] O_FILE_DATA,
  output logic O_PC_RELOAD,
  output logic O_DONE
);

  // state toward the core; each register has its own next value
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  alu_slice_pkg::flags_type flags_reg;
  alu_slice_pkg::flags_type flags_next;
  logic file_we_reg;
  logic file_we_next;
  logic [6:0] file_addr_reg;
  logic [6:0] file_addr_next;
  logic [7:0] file_data_reg;
  logic [7:0] file_data_next;
  logic pc_reload_reg;
  logic pc_reload_next;
  logic done_reg;
  logic done_next;
  logic [1:0] ret_count_reg;
  logic [1:0] ret_count_next;
  logic busy_reg;
  logic busy_next;
  alu_slice_pkg::flags_type rot_flags;
  alu_slice_pkg::flags_type sub_flags;

  // one opcode compare, shared by every decode line
  function automatic logic op_is(
    input alu_slice_pkg::op_type code,
    input alu_slice_pkg::op_type want
  );
    op_is = code == want;
  endfunction : op_is

  // the top bit of a widened difference is the borrow; carry is its inverse
  function automatic logic no_borrow(
    input logic top_bit
  );
    no_borrow = !top_bit;
  endfunction : no_borrow

  // request decode; codes the slice does not know are taken and do nothing
  wire take = I_VALID && !busy_reg;
  wire is_rr = op_is(I_REQ.op, alu_slice_pkg::OP_ROTATE_RIGHT);
  wire is_rl = op_is(I_REQ.op, alu_slice_pkg::OP_ROTATE_LEFT);
  wire is_sub = op_is(I_REQ.op, alu_slice_pkg::OP_LITERAL_MINUS_ACC);
  wire is_ret = op_is(I_REQ.op, alu_slice_pkg::OP_RETURN_WITH_LITERAL);
  wire is_rot = is_rr || is_rl;
  wire take_rot = take && is_rot;
  wire take_sub = take && is_sub;
  wire take_ret = take && is_ret;
  wire take_single = take && (is_rot || is_sub);

  // rotations through carry; inner bits move one place, the end bits meet the carry
  wire [7:0] rr_result;
  wire [7:0] rl_result;
  generate
    for (genvar bit_idx = 0; bit_idx < alu_slice_pkg::DATA_W - 1; bit_idx = bit_idx + 1) begin : g_shift
      assign rr_result[bit_idx] = I_REQ.file_data[bit_idx + 1]; // [RL1]
      assign rl_result[bit_idx + 1] = I_REQ.file_data[bit_idx]; // [RL8]
    end
  endgenerate
  assign rr_result[7] = flags_reg.carry; // [RL1]
  assign rl_result[0] = flags_reg.carry; // [RL8]
  wire rr_carry = I_REQ.file_data[0]; // [RL1]
  wire rl_carry = I_REQ.file_data[7]; // [RL8]
  wire [7:0] rot_result = is_rr ? rr_result : rl_result;
  wire rot_carry = is_rr ? rr_carry : rl_carry;
  // the destination bit only steers the result; the decoder must forward a pending write-back
  wire rot_to_file = I_REQ.dest == alu_slice_pkg::DEST_FILE; // [RL2]
  wire rot_to_acc = I_REQ.dest == alu_slice_pkg::DEST_ACC; // [RL2]
  wire [6:0] rot_addr = I_REQ.addr; // [RL1]

  // subtraction in nine and five bits so that both borrows fall out directly
  wire [8:0] diff = {1'h0, I_REQ.literal} - {1'h0, acc_reg}; // [RL3]
  wire [4:0] nib_diff = {1'h0, I_REQ.literal[3:0]} - {1'h0, acc_reg[3:0]}; // [RL5]
  wire [7:0] sub_result = diff[7:0]; // [RL3]
  wire sub_carry = no_borrow(diff[8]); // [RL5]
  wire sub_nibble = no_borrow(nib_diff[4]); // [RL5]
  wire sub_zero = sub_result == 8'h00; // [RL4]

  // rotates keep nibble carry and zero; the subtraction replaces all three
  assign rot_flags = '{carry: rot_carry, nibble_carry: flags_reg.nibble_carry, zero: flags_reg.zero}; // [RL8]
  assign sub_flags = '{carry: sub_carry, nibble_carry: sub_nibble, zero: sub_zero}; // [RL4]

  // return sequencing: the count is loaded on take and walks down to the last cycle
  wire [1:0] ret_start = 2'(alu_slice_pkg::RETURN_CYCLES - 1); // [RL6]
  wire ret_last = ret_count_reg == alu_slice_pkg::RETURN_LAST;
  wire ret_finish = busy_reg && ret_last; // [RL6]

  // next values; acc, flags, file address and data hold unless their op is taken; the write, pc and done strobes clear
  assign acc_next = (take_rot && rot_to_acc) ? rot_result // [RL2]
    : take_sub ? sub_result // [RL4]
    : take_ret ? I_REQ.literal // [RL7]
    : acc_reg;
  assign flags_next = take_rot ? rot_flags : take_sub ? sub_flags : flags_reg;
  assign file_we_next = take_rot && rot_to_file; // [RL2]
  assign file_addr_next = take_rot ? rot_addr : file_addr_reg;
  assign file_data_next = take_rot ? rot_result : file_data_reg;
  assign ret_count_next = take_ret ? ret_start // [RL6]
    : ret_finish ? 2'h0
    : busy_reg ? ret_count_reg - 2'h1
    : ret_count_reg;
  assign busy_next = take_ret || (busy_reg && !ret_last); // [RL6]
  assign pc_reload_next = ret_finish; // [RL7]
  assign done_next = take_single || ret_finish; // [RL6]

  // accumulator
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      acc_reg <= alu_slice_pkg::ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // status flags
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // write strobe lasts one cycle; literal subtraction never writes a file register
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      file_we_reg <= 1'h0;
    end else begin
      file_we_reg <= file_we_next;
    end
  end

  // address and data stand until the next rotate
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      file_addr_reg <= '0;
    end else begin
      file_addr_reg <= file_addr_next;
    end
  end

  // held so the core may latch it on any cycle of the strobe
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      file_data_reg <= '0;
    end else begin
      file_data_reg <= file_data_next;
    end
  end

  // return cycle counter
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ret_count_reg <= 2'h0;
    end else begin
      ret_count_reg <= ret_count_next;
    end
  end

  // busy refuses the request that lands in the second return cycle; it is not queued
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      busy_reg <= 1'h0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  // pc reload comes with done, in the cycle after the last return cycle
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      pc_reload_reg <= 1'h0;
    end else begin
      pc_reload_reg <= pc_reload_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      done_reg <= 1'h0;
    end else begin
      done_reg <= done_next;
    end
  end

  // every output is a register, so the core sees no path through the slice
  assign O_ACC = acc_reg;
  assign O_FLAGS = flags_reg;
  assign O_FILE_WE = file_we_reg;
  assign O_FILE_ADDR = file_addr_reg;
  assign O_FILE_DATA = file_data_reg;
  assign O_PC_RELOAD = pc_reload_reg;
  assign O_DONE = done_reg;
  assign O_BUSY = busy_reg;

endmodule : rotate_subtract_alu_slice

// ### tb/file_model.sv
// Purpose: register file and decoder side model. Assumes: one clock. Notes: reads are combinational
`timescale 1ns/1ps
module file_model(input wire logic clk, input wire logic we, input wire logic [6:0] wa,
  input wire logic [7:0] wd, input wire logic [6:0] ra, output logic [7:0] rd);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
  always @(posedge clk) if (we) mem[wa] <= wd;
  // forward the pending write-back, the slice does not bypass it itself
  assign rd = (we && wa == ra) ? wd : mem[ra];
endmodule : file_model

// ### tb/alu_slice_monitor.sv
// Purpose: port checks. Assumes: one clock. Notes: bound to the slice
`timescale 1ns/1ps
module alu_slice_monitor(input wire logic I_CORE_CLK, I_RESET, I_VALID, O_BUSY, O_FILE_WE, O_PC_RELOAD, O_DONE,
  input wire logic [7:0] O_ACC, O_FILE_DATA, input wire logic [6:0] O_FILE_ADDR,
  input wire alu_slice_pkg::request_type I_REQ, input wire alu_slice_pkg::flags_type O_FLAGS);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  wire tk = I_VALID && !O_BUSY;
  wire rr = tk && I_REQ.op == alu_slice_pkg::OP_ROTATE_RIGHT;
  wire rl = tk && I_REQ.op == alu_slice_pkg::OP_ROTATE_LEFT;
  wire sb = tk && I_REQ.op == alu_slice_pkg::OP_LITERAL_MINUS_ACC;
  wire rt = tk && I_REQ.op == alu_slice_pkg::OP_RETURN_WITH_LITERAL;
  wire [7:0] f = I_REQ.file_data;
  wire [7:0] k = I_REQ.literal;
  wire c = O_FLAGS.carry;
  sequence ret_s; O_BUSY && !O_DONE ##1 O_PC_RELOAD && O_DONE && !O_BUSY; endsequence
  a_rotr_file: assert property (rr && I_REQ.dest |=> O_FILE_WE && O_FILE_DATA == {$past(c), $past(f[7:1])} && c == $past(f[0]))
    else $error("rotate right write-back wrong");
  a_rotr_acc: assert property (rr && !I_REQ.dest |=> !O_FILE_WE && O_ACC == {$past(c), $past(f[7:1])})
    else $error("rotate right to acc wrong");
  a_rotl_only: assert property (rl |=> c == $past(f[7]) && $stable(O_FLAGS.zero) && $stable(O_FLAGS.nibble_carry)
    && O_FILE_WE == $past(I_REQ.dest) && (O_FILE_WE ? O_FILE_DATA : O_ACC) == {$past(f[6:0]), $past(c)}) else $error("rotate left wrong");
  a_sub_value: assert property (sb |=> O_ACC == $past(8'(k - O_ACC)) && O_FLAGS.zero == (O_ACC == 8'h00))
    else $error("difference wrong");
  a_sub_dest: assert property (sb |=> !O_FILE_WE && O_DONE)
    else $error("difference not to acc");
  a_sub_carry: assert property (sb |=> c == $past(O_ACC <= k) && O_FLAGS.nibble_carry == $past(O_ACC[3:0] <= k[3:0]))
    else $error("borrow flags wrong");
  a_ret_cycles: assert property (rt |=> ret_s)
    else $error("return timing wrong");
  a_ret_acc: assert property (rt |=> O_ACC == $past(k) && !O_FILE_WE)
    else $error("return literal wrong");
endmodule : alu_slice_monitor
bind rotate_subtract_alu_slice alu_slice_monitor i_mon(.*);

// ### tb/test_rotate_subtract_alu_slice.sv
// Purpose: random ops against an integer model. Assumes: one clock. Notes: checked each cycle
`timescale 1ns/1ps
module test_rotate_subtract_alu_slice;
  logic clk = 0, rst = 1, v = 0;
  alu_slice_pkg::request_type rq = '0;
  wire logic [7:0] fd, acc_o, wd_o;
  wire logic [6:0] wa_o;
  wire alu_slice_pkg::flags_type fl_o;
  wire logic bsy_o, we_o, pc_o, dn_o;
  int acc = 0, c = 0, dc = 0, z = 0, eb = 0, ew = 0, ep = 0, ed = 0, ewd = 0, ewa = 0, f, r;
  int seed = 54536, mismatches = 0, num_checks = 0;
  file_model i_file(.clk(clk), .we(we_o), .wa(wa_o), .wd(wd_o), .ra(rq.addr), .rd(fd));
  rotate_subtract_alu_slice i_dut(.I_CORE_CLK(clk), .I_RESET(rst), .I_VALID(v), .I_REQ({rq[26:8], fd}),
    .O_BUSY(bsy_o), .O_ACC(acc_o), .O_FLAGS(fl_o), .O_FILE_WE(we_o), .O_FILE_ADDR(wa_o),
    .O_FILE_DATA(wd_o), .O_PC_RELOAD(pc_o), .O_DONE(dn_o));
  initial forever #12.5 clk = ~clk;
  task chk(string n, int e, logic [7:0] g);
    num_checks++;
    if (g !== 8'(e)) begin mismatches++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end
  endtask : chk
  task check_acc(int e);
    chk("acc", e, acc_o);
  endtask : check_acc
  task check_flags(int e);
    chk("flags", e, {5'h0, fl_o});
  endtask : check_flags
  task check_strobes(int e);
    chk("strobes", e, {4'h0, bsy_o, we_o, pc_o, dn_o});
  endtask : check_strobes
  task check_write_addr(int e);
    chk("file addr", e, {1'h0, wa_o});
  endtask : check_write_addr
  task check_write_data(int e);
    chk("file data", e, wd_o);
  endtask : check_write_data
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 0;
    repeat (800) begin
      @(negedge clk);
      check_acc(acc);
      check_flags(c * 4 + dc * 2 + z);
      check_strobes(eb * 8 + ew * 4 + ep * 2 + ed);
      if (ew) check_write_addr(ewa);
      if (ew) check_write_data(ewd);
      ep = eb; ed = eb; ew = 0; eb = 0;
      v = $random(seed) % 8 != 0;
      rq.op = alu_slice_pkg::op_type'(3'($unsigned($random(seed)) % 5));
      {rq.dest, rq.addr, rq.literal} = 16'($random(seed));
      #1 f = fd;
      if (v && !ep) case (rq.op)
        alu_slice_pkg::OP_ROTATE_RIGHT, alu_slice_pkg::OP_ROTATE_LEFT: begin
          r = rq.op == alu_slice_pkg::OP_ROTATE_RIGHT ? c * 128 + f / 2 : (f * 2) % 256 + c;
          c = rq.op == alu_slice_pkg::OP_ROTATE_RIGHT ? f % 2 : f / 128;
          if (rq.dest) begin ew = 1; ewd = r; ewa = rq.addr; end else acc = r;
          ed = 1;
        end
        alu_slice_pkg::OP_LITERAL_MINUS_ACC: begin
          c = acc <= rq.literal; dc = acc % 16 <= rq.literal % 16;
          acc = (rq.literal - acc + 256) % 256; z = acc == 0; ed = 1;
        end
        alu_slice_pkg::OP_RETURN_WITH_LITERAL: begin acc = rq.literal; eb = 1; end
        default: ;
      endcase
    end
    report_and_stop();
  end
endmodule : test_rotate_subtract_alu_slice
